// ==== rtl/css_pkg.sv ====
package css_pkg;
	localparam int CSS_STEPS = 5;
	localparam int CSS_DOUTS = 4;
	localparam int CSS_PW = 16;
	localparam int CSS_TW = 16;
	localparam int CSS_SW = 8;
	localparam int CSS_DW = 16;
	localparam int CSS_LW = 3;

	localparam logic [7:0] CSS_OFS_CTRL = 8'h00;
	localparam logic [7:0] CSS_OFS_SETP = 8'h04;
	localparam logic [7:0] CSS_OFS_BAND = 8'h08;
	localparam logic [7:0] CSS_OFS_TEMP = 8'h0c;
	localparam logic [7:0] CSS_OFS_SPD = 8'h10;
	localparam logic [7:0] CSS_OFS_HLD = 8'h14;
	localparam logic [7:0] CSS_OFS_STAT = 8'h18;
	localparam logic [7:0] CSS_OFS_STEP0 = 8'h20;

	localparam int CSS_CTRL_MODE_LSB = 0;
	localparam int CSS_CTRL_PROF_BIT = 2;
	localparam int CSS_CTRL_AUTOSW_BIT = 3;
	localparam int CSS_CTRL_WETB_BIT = 4;
	localparam int CSS_CTRL_TOG_LSB = 8;
	localparam int CSS_ST_SUM_LSB = 0;
	localparam int CSS_ST_WIN_LSB = 5;
	localparam int CSS_ST_EN_BIT = 10;
	localparam int CSS_ST_LOW_LSB = 11;
	localparam int CSS_ST_DLY_LSB = 16;

	localparam logic [31:0] CSS_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CSS_STEP_RST = 32'h0000_0000;
	localparam logic [31:0] CSS_UNMAPPED = 32'h0000_0000;

	typedef enum logic [1:0] {
		CSS_NEVER,
		CSS_WITH_COMP,
		CSS_ALWAYS,
		CSS_MANUAL
	} css_mode_e;

	typedef struct packed {
		logic [CSS_PW-1:0] cond_press;
		logic [CSS_TW-1:0] ambient;
		logic [CSS_TW-1:0] wetbulb;
		logic [CSS_TW-1:0] cond_temp;
		logic [CSS_SW-1:0] fan_speed;
		logic comp_run;
	} css_sense_s;

	typedef struct packed {
		logic [CSS_DOUTS-1:0] dout;
		logic vfd_en;
	} css_out_s;
endpackage : css_pkg

// ==== rtl/css_sequencer.sv ====
`timescale 1ns/1ps
// Operation
// RULE_01 - four run modes: never, with compressor, always, manual; never after reset
// RULE_02 - never mode: no staging, all stage outputs off
// RULE_03 - with-compressor mode stages automatically only while compressor runs
// RULE_04 - always mode stages automatically regardless of compressor
// RULE_05 - manual mode: each stage switched only by its toggle
// RULE_06 - no stage added while pressure inside upper deadband
// RULE_07 - no stage removed while pressure inside lower deadband
// RULE_08 - above upper deadband advance stage upward toward fifth
// RULE_09 - below lower deadband retreat stage downward toward first
// RULE_10 - change only after continuous full delay outside band; return restarts
// RULE_11 - in variable-speed stage, add only at maximum speed and delay expired
// RULE_12 - in variable-speed stage, remove only at minimum speed and delay expired
// RULE_13 - one per-stage delay used as on-delay and off-delay
// RULE_14 - four digital outputs plus variable-speed fan, each stage maps up to five
// RULE_15 - stages included or skipped by their enable bit
// RULE_16 - low-speed output held off for spin-down delay; next timer waits for it
// RULE_17 - toggles accepted only in manual; auto reports active stage as on
// RULE_18 - summer and winter mapping profiles for all five stages
// RULE_19 - auto switch: winter below switch temperature, summer above
// RULE_20 - manual profile ignored while auto runs with auto switching
// RULE_21 - wetbulb override: no further stages once condenser temp reaches limit
// RULE_22 - ambient equal to switch temperature keeps current profile
// RULE_23 - auto staging inactive: outputs off, back to lowest stage
module css_sequencer
	import css_pkg::*;
#(
	parameter int STEPS = CSS_STEPS,
	parameter int TICK_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire css_pkg::css_sense_s sense,
	output css_pkg::css_out_s drive,
	output logic [CSS_SW-1:0] vfd_speed_out,
	output logic [STEPS-1:0] control_ind,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import css_pkg::*;

	// register file
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [31:0] setp_r, setp_nxt, band_r, band_nxt, temp_r, temp_nxt;
	logic [31:0] spd_r, spd_nxt, hld_r, hld_nxt;
	logic [31:0] step_r [STEPS];
	logic [31:0] step_nxt [STEPS];
	logic [31:0] rdata_r, rdata_nxt;
	logic ack_r, ack_nxt;

	// sequencer state
	logic [2:0] stage_r, stage_nxt;
	logic [CSS_DW-1:0] dly_r, dly_nxt;
	logic [CSS_DW-1:0] hl_r, hl_nxt;
	logic prof_win_r, prof_win_nxt;
	logic [STEPS-1:0] man_on_r, man_on_nxt;
	css_out_s drive_r, drive_nxt;
	logic [CSS_SW-1:0] spd_out_r, spd_out_nxt;
	logic [STEPS-1:0] ind_r, ind_nxt;

	css_mode_e mode;
	logic auto_run, above, below, wet_stop, sp_hi, sp_lo;
	logic cur_vfd, hl_busy, can_up, can_dn;
	logic [2:0] up_idx, dn_idx;
	logic [CSS_DW-1:0] cur_dly;
	logic [STEPS-1:0] tog;
	logic [CSS_PW:0] hi_lim, lo_lim;
	logic [CSS_TW:0] wet_lim;
	logic [4:0] map_cur;
	logic [CSS_LW-1:0] low_cur;

	assign mode = css_mode_e'(ctrl_r[CSS_CTRL_MODE_LSB +: 2]); // see RULE_01
	assign tog = ctrl_r[CSS_CTRL_TOG_LSB +: STEPS];

	// single-cycle ack keeps the master waiting exactly one edge
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata = rdata_r;

	always_comb begin
		ctrl_nxt = ctrl_r;
		setp_nxt = setp_r;
		band_nxt = band_r;
		temp_nxt = temp_r;
		spd_nxt = spd_r;
		hld_nxt = hld_r;
		for (int i = 0; i < STEPS; i++) begin
			step_nxt[i] = step_r[i];
		end
		ack_nxt = (avs_read | avs_write) & ~ack_r;
		rdata_nxt = rdata_r;
		// commit on the accepting edge, where waitrequest is seen low
		if (avs_write && ack_r) begin
			case (avs_address)
				CSS_OFS_CTRL: ctrl_nxt = avs_writedata;
				CSS_OFS_SETP: setp_nxt = avs_writedata;
				CSS_OFS_BAND: band_nxt = avs_writedata;
				CSS_OFS_TEMP: temp_nxt = avs_writedata;
				CSS_OFS_SPD: spd_nxt = avs_writedata;
				CSS_OFS_HLD: hld_nxt = avs_writedata;
				default: begin
					for (int i = 0; i < STEPS; i++) begin
						if (avs_address == CSS_OFS_STEP0 + 8'(4 * i)) begin
							step_nxt[i] = avs_writedata;
						end
					end
				end
			endcase
		end
		if (avs_read && !ack_r) begin
			case (avs_address)
				CSS_OFS_CTRL: rdata_nxt = ctrl_r;
				CSS_OFS_SETP: rdata_nxt = setp_r;
				CSS_OFS_BAND: rdata_nxt = band_r;
				CSS_OFS_TEMP: rdata_nxt = temp_r;
				CSS_OFS_SPD: rdata_nxt = spd_r;
				CSS_OFS_HLD: rdata_nxt = hld_r;
				CSS_OFS_STAT: rdata_nxt = {16'h0000, 3'h0, ind_r,
					prof_win_r, 4'h0, stage_r};
				default: begin
					rdata_nxt = CSS_UNMAPPED;
					for (int i = 0; i < STEPS; i++) begin
						if (avs_address == CSS_OFS_STEP0 + 8'(4 * i)) begin
							rdata_nxt = step_r[i];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= CSS_CTRL_RST;
			setp_r <= 32'h0000_0000;
			band_r <= 32'h0000_0000;
			temp_r <= 32'h0000_0000;
			spd_r <= 32'h0000_0000;
			hld_r <= 32'h0000_0000;
			for (int i = 0; i < STEPS; i++) begin
				step_r[i] <= CSS_STEP_RST;
			end
			rdata_r <= 32'h0000_0000;
			ack_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			setp_r <= setp_nxt;
			band_r <= band_nxt;
			temp_r <= temp_nxt;
			spd_r <= spd_nxt;
			hld_r <= hld_nxt;
			for (int i = 0; i < STEPS; i++) begin
				step_r[i] <= step_nxt[i];
			end
			rdata_r <= rdata_nxt;
			ack_r <= ack_nxt;
		end
	end

	// band limits, widened by one bit so a large band cannot wrap
	assign hi_lim = {1'b0, setp_r[CSS_PW-1:0]} + {1'b0, band_r[15:0]};
	assign lo_lim = {1'b0, setp_r[CSS_PW-1:0]} - {1'b0, band_r[31:16]};
	assign above = {1'b0, sense.cond_press} > hi_lim; // see RULE_06
	assign below = ({1'b0, sense.cond_press} < lo_lim) && !lo_lim[CSS_PW]; // see RULE_07
	assign wet_lim = {1'b0, sense.wetbulb} + {1'b0, temp_r[31:16]};
	assign wet_stop = ctrl_r[CSS_CTRL_WETB_BIT]
		&& ({1'b0, sense.cond_temp} >= wet_lim); // see RULE_21
	assign sp_hi = sense.fan_speed >= spd_r[15:8]; // see RULE_11
	assign sp_lo = sense.fan_speed <= spd_r[7:0]; // see RULE_12

	assign auto_run = (mode == CSS_ALWAYS) // see RULE_04
		|| (mode == CSS_WITH_COMP && sense.comp_run); // see RULE_03

	// stage 0 is idle; stage k means sequence step k is active
	always_comb begin
		up_idx = 3'd0;
		for (int i = STEPS; i >= 1; i--) begin
			if (i > stage_r && step_r[i-1][CSS_ST_EN_BIT]) begin
				up_idx = 3'(i); // see RULE_15
			end
		end
		dn_idx = 3'd0;
		for (int i = 1; i <= STEPS; i++) begin
			if (i < stage_r && step_r[i-1][CSS_ST_EN_BIT]) begin
				dn_idx = 3'(i);
			end
		end
	end

	always_comb begin
		map_cur = 5'h00;
		low_cur = '0;
		cur_dly = '0;
		cur_vfd = 1'b0;
		if (stage_r != 3'd0) begin
			map_cur = prof_win_r ? step_r[stage_r-1][CSS_ST_WIN_LSB +: 5]
				: step_r[stage_r-1][CSS_ST_SUM_LSB +: 5]; // see RULE_18
			low_cur = step_r[stage_r-1][CSS_ST_LOW_LSB +: CSS_LW];
			cur_vfd = map_cur[CSS_DOUTS];
		end
		// one delay per step, on-delay loading into it, off-delay leaving it
		if (above && up_idx != 3'd0) begin
			cur_dly = step_r[up_idx-1][CSS_ST_DLY_LSB +: CSS_DW]; // see RULE_13
		end else if (below && stage_r != 3'd0) begin
			cur_dly = step_r[stage_r-1][CSS_ST_DLY_LSB +: CSS_DW]; // see RULE_13
		end
	end

	assign hl_busy = hl_r != '0;
	assign can_up = above && up_idx != 3'd0 && !wet_stop && !hl_busy
		&& (!cur_vfd || sp_hi); // see RULE_16
	assign can_dn = below && stage_r != 3'd0 && (!cur_vfd || sp_lo);

	always_comb begin
		stage_nxt = stage_r;
		dly_nxt = dly_r;
		hl_nxt = hl_r;
		prof_win_nxt = prof_win_r;
		man_on_nxt = man_on_r;
		// auto switch only in auto modes; equality holds current profile
		if (auto_run && ctrl_r[CSS_CTRL_AUTOSW_BIT]) begin // see RULE_20
			if (sense.ambient < temp_r[15:0]) begin
				prof_win_nxt = 1'b1; // see RULE_19
			end else if (sense.ambient > temp_r[15:0]) begin
				prof_win_nxt = 1'b0; // see RULE_22
			end
		end else begin
			prof_win_nxt = ctrl_r[CSS_CTRL_PROF_BIT];
		end
		if (mode == CSS_MANUAL) begin
			man_on_nxt = tog; // see RULE_05
			stage_nxt = 3'd0;
			dly_nxt = '0;
			hl_nxt = '0;
		end else if (!auto_run) begin
			man_on_nxt = '0;
			stage_nxt = 3'd0; // see RULE_23
			dly_nxt = '0;
			hl_nxt = '0;
		end else begin
			man_on_nxt = '0;
			if (hl_busy && tick) begin
				hl_nxt = hl_r - 1'b1;
			end
			if (!(can_up || can_dn)) begin
				dly_nxt = '0; // see RULE_10
			end else if (dly_r < cur_dly) begin
				if (tick) begin
					dly_nxt = dly_r + 1'b1;
				end
			end else if (can_up) begin
				stage_nxt = up_idx; // see RULE_08
				dly_nxt = '0;
				if (step_r[up_idx-1][CSS_ST_LOW_LSB +: CSS_LW] != '0) begin
					hl_nxt = hld_r[CSS_DW-1:0];
				end
			end else begin
				stage_nxt = dn_idx; // see RULE_09
				dly_nxt = '0;
				hl_nxt = '0;
			end
		end
	end

	always_comb begin
		drive_nxt = '0;
		spd_out_nxt = '0;
		ind_nxt = '0;
		if (mode == CSS_MANUAL) begin
			for (int i = 0; i < STEPS; i++) begin
				if (man_on_r[i]) begin
					drive_nxt.dout = drive_nxt.dout | (prof_win_r
						? step_r[i][CSS_ST_WIN_LSB +: CSS_DOUTS]
						: step_r[i][CSS_ST_SUM_LSB +: CSS_DOUTS]);
					drive_nxt.vfd_en = drive_nxt.vfd_en | (prof_win_r
						? step_r[i][CSS_ST_WIN_LSB + CSS_DOUTS]
						: step_r[i][CSS_ST_SUM_LSB + CSS_DOUTS]);
				end
			end
			ind_nxt = man_on_r; // see RULE_17
		end else if (auto_run && stage_r != 3'd0) begin
			drive_nxt.dout = map_cur[CSS_DOUTS-1:0]; // see RULE_14
			drive_nxt.vfd_en = map_cur[CSS_DOUTS];
			// spin-down: low-speed output stays off until the hold ends
			if (hl_busy && low_cur != '0 && low_cur <= CSS_LW'(CSS_DOUTS)) begin
				drive_nxt.dout[low_cur-1] = 1'b0; // see RULE_16
			end
			ind_nxt[stage_r-1] = 1'b1; // see RULE_17
		end
		if (drive_nxt.vfd_en) begin
			spd_out_nxt = sense.fan_speed;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage_r <= 3'd0;
			dly_r <= '0;
			hl_r <= '0;
			prof_win_r <= 1'b0;
			man_on_r <= '0;
			drive_r <= '0;
			spd_out_r <= '0;
			ind_r <= '0;
		end else begin
			stage_r <= stage_nxt;
			dly_r <= dly_nxt;
			hl_r <= hl_nxt;
			prof_win_r <= prof_win_nxt;
			man_on_r <= man_on_nxt;
			drive_r <= drive_nxt;
			spd_out_r <= spd_out_nxt;
			ind_r <= ind_nxt;
		end
	end

	assign drive = drive_r;
	assign vfd_speed_out = spd_out_r;
	assign control_ind = ind_r;

	never_off_a: assert property (@(posedge clk) disable iff (rst)
		mode == CSS_NEVER |=> ##1 drive_r == '0)
		else $error("outputs active in never mode"); // see RULE_02
	comp_stop_a: assert property (@(posedge clk) disable iff (rst)
		(mode == CSS_WITH_COMP && !sense.comp_run) |=> stage_r == 3'd0)
		else $error("staging with compressor stopped"); // see RULE_03
	up_band_a: assert property (@(posedge clk) disable iff (rst)
		!above && mode != CSS_MANUAL |=> stage_r <= $past(stage_r))
		else $error("stage added inside upper band"); // see RULE_06
	down_band_a: assert property (@(posedge clk) disable iff (rst)
		!below && auto_run && $past(auto_run) |=> stage_r >= $past(stage_r))
		else $error("stage removed inside lower band"); // see RULE_07
	wet_hold_a: assert property (@(posedge clk) disable iff (rst)
		wet_stop && auto_run |=> stage_r <= $past(stage_r))
		else $error("stage added past wetbulb limit"); // see RULE_21
	dly_full_a: assert property (@(posedge clk) disable iff (rst)
		auto_run && stage_nxt > stage_r |-> dly_r >= cur_dly)
		else $error("stage advanced before delay"); // see RULE_10
	vfd_max_a: assert property (@(posedge clk) disable iff (rst)
		auto_run && cur_vfd && stage_nxt > stage_r |-> sp_hi)
		else $error("stage added below max speed"); // see RULE_11
	vfd_min_a: assert property (@(posedge clk) disable iff (rst)
		auto_run && cur_vfd && stage_nxt < stage_r |-> sp_lo)
		else $error("stage removed above min speed"); // see RULE_12
	manual_tog_a: assert property (@(posedge clk) disable iff (rst)
		mode == CSS_MANUAL ##1 mode == CSS_MANUAL
		|=> ind_r == $past(tog, 2))
		else $error("manual indication mismatch"); // see RULE_05
endmodule : css_sequencer

// ==== verification/css_vfd_model.sv ====
`timescale 1ns/1ps
// drive seen from the panel: speed follows pid demand while enabled
module css_vfd_model
	import css_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire css_pkg::css_out_s drive,
	input wire logic [CSS_SW-1:0] demand,
	output logic [CSS_SW-1:0] fan_speed
);
	logic [CSS_SW-1:0] speed_r;
	logic [CSS_SW-1:0] speed_nxt;
	// disabled drive drops to zero at the next edge, so a stale speed never reads back
	always_comb begin
		speed_nxt = drive.vfd_en ? demand : 8'h00;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			speed_r <= 8'h00;
		end else begin
			speed_r <= speed_nxt;
		end
	end
	assign fan_speed = speed_r;
endmodule : css_vfd_model

// ==== verification/tb_css_sequencer.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
	mismatches++; $display("mismatch %s expected %0h seen %0h", n, e, g); \
	end end
module tb_css_sequencer;
	import css_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic tick = 1'b0;
	logic comp = 1'b0;
	logic [15:0] press = 16'h0000;
	logic [15:0] amb = 16'h0000;
	logic [7:0] demand = 8'h00;
	logic [7:0] spd;
	css_sense_s sense;
	css_out_s drive;
	logic [7:0] vfd_speed_out;
	logic [4:0] control_ind;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [31:0] rdata;
	int mismatches = 0;
	int checked = 0;
	always #2.5 clk = ~clk;
	// wetbulb and condenser temperature tied at zero: override trips whenever enabled
	assign sense = {press, amb, 16'h0000, 16'h0000, spd, comp};
	css_sequencer i_css_sequencer (.clk(clk), .rst(rst), .tick(tick),
		.sense(sense), .drive(drive), .vfd_speed_out(vfd_speed_out),
		.control_ind(control_ind), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	css_vfd_model i_css_vfd_model (.clk(clk), .rst(rst), .drive(drive),
		.demand(demand), .fan_speed(spd));
	task automatic end_sim;
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	// read just after the edge: the value that edge itself sampled
	task automatic bus(input logic rd, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= ~rd;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				mismatches++;
				end_sim();
			end
		end
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic tk(input int n);
		repeat (n) begin
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask : tk
	task automatic st(input logic [2:0] s, input logic [3:0] d,
		input logic v);
		repeat (2) @(posedge clk);
		bus(1'b1, CSS_OFS_STAT, 32'h0000_0000);
		@(negedge clk);
		`CHK("stage", s, rdata[2:0])
		`CHK("dout", d, drive.dout)
		`CHK("vfd_en", v, drive.vfd_en)
		@(posedge clk);
	endtask : st
	task automatic t_reset;
		bus(1'b0, 8'hfc, 32'hffff_ffff);
		bus(1'b1, CSS_OFS_CTRL, 32'h0000_0000);
		`CHK("ctrl", CSS_CTRL_RST, rdata)
		st(3'h0, 4'h0, 1'b0);
		bus(1'b0, CSS_OFS_SETP, 32'h0000_0064);
		bus(1'b0, CSS_OFS_BAND, 32'h0005_0005);
		bus(1'b0, CSS_OFS_TEMP, 32'h0000_0020);
		bus(1'b0, CSS_OFS_SPD, 32'h0000_5f05);
		bus(1'b0, CSS_OFS_STEP0, 32'h0002_0451);
		bus(1'b0, CSS_OFS_STEP0 + 8'h04, 32'h0001_0002);
		bus(1'b0, CSS_OFS_STEP0 + 8'h08, 32'h0003_0504);
	endtask : t_reset
	task automatic t_always;
		bus(1'b0, CSS_OFS_CTRL, 32'h0000_0002);
		demand <= 8'h32;
		press <= 16'h0067;
		tk(3);
		st(3'h0, 4'h0, 1'b0);
		press <= 16'h006e;
		tk(1);
		st(3'h0, 4'h0, 1'b0);
		tk(1);
		st(3'h1, 4'h1, 1'b1);
		`CHK("speed", 8'h32, vfd_speed_out)
		`CHK("ind", 5'h01, control_ind)
		tk(4);
		st(3'h1, 4'h1, 1'b1);
		press <= 16'h0067;
		demand <= 8'h64;
		tk(1);
		press <= 16'h006e;
		tk(2);
		press <= 16'h0067;
		tk(1);
		press <= 16'h006e;
		tk(2);
		st(3'h1, 4'h1, 1'b1);
		tk(1);
		st(3'h3, 4'h4, 1'b0);
		`CHK("ind", 5'h04, control_ind)
		press <= 16'h005a;
		tk(2);
		st(3'h3, 4'h4, 1'b0);
		tk(1);
		st(3'h1, 4'h1, 1'b1);
		tk(3);
		st(3'h1, 4'h1, 1'b1);
		demand <= 8'h00;
		tk(3);
		st(3'h0, 4'h0, 1'b0);
		press <= 16'h0067;
	endtask : t_always
	task automatic t_comp;
		bus(1'b0, CSS_OFS_CTRL, 32'h0000_0001);
		press <= 16'h006e;
		tk(3);
		st(3'h0, 4'h0, 1'b0);
		comp <= 1'b1;
		tk(2);
		st(3'h1, 4'h1, 1'b1);
		comp <= 1'b0;
		st(3'h0, 4'h0, 1'b0);
	endtask : t_comp
	task automatic t_profile;
		bus(1'b0, CSS_OFS_CTRL, 32'h0000_000e);
		amb <= 16'h000a;
		tk(2);
		st(3'h1, 4'h2, 1'b0);
		`CHK("winter", 1'b1, rdata[7])
		amb <= 16'h0020;
		tk(1);
		st(3'h1, 4'h2, 1'b0);
		amb <= 16'h0028;
		tk(1);
		st(3'h1, 4'h1, 1'b1);
	endtask : t_profile
	task automatic t_wet;
		demand <= 8'h64;
		bus(1'b0, CSS_OFS_CTRL, 32'h0000_0012);
		tk(5);
		st(3'h1, 4'h1, 1'b1);
		bus(1'b0, CSS_OFS_HLD, 32'h0000_0002);
		bus(1'b0, CSS_OFS_STEP0 + 8'h08, 32'h0003_1d04);
		bus(1'b0, CSS_OFS_CTRL, 32'h0000_0002);
		tk(4);
		st(3'h3, 4'h0, 1'b0);
		tk(1);
		st(3'h3, 4'h4, 1'b0);
		demand <= 8'h00;
	endtask : t_wet
	task automatic t_manual;
		bus(1'b0, CSS_OFS_CTRL, 32'h0000_0503);
		st(3'h0, 4'h5, 1'b1);
		`CHK("ind", 5'h05, control_ind)
		bus(1'b0, CSS_OFS_CTRL, 32'h0000_0403);
		st(3'h0, 4'h4, 1'b0);
		bus(1'b0, CSS_OFS_CTRL, 32'h0000_0500);
		tk(3);
		st(3'h0, 4'h0, 1'b0);
	endtask : t_manual
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_always();
		t_comp();
		t_profile();
		t_wet();
		t_manual();
		end_sim();
	end
endmodule : tb_css_sequencer
